// file: hw/jes_interlock.sv
// Purpose: jog enable source register and start/jog interlock
// Assumes: all inputs synchronous to clock; one clock at 40 MHz
// Notes:   enable is taken on a rising source only, a level held high never re-arms
//
// How it works
// - A programmable selector register picks the signal that acts as jog enable.
// - Codes 2 to 5 route debounced input word bits 0 to 3 to the enable.
// - Codes 24 to 29 route supervision status bits 0 to 5 to the enable.
// - A selected value of 1 allows jogging and a value of 0 keeps it off.
// - Jogging acts only in vector control mode and jog requests do nothing otherwise.
// - A rising enable is accepted only when no external start command is active.
// - While jogging is enabled external starts are blocked except fieldbus inching.
// - The enable only gates jogging; jog 1 and jog 2 come from their own start inputs.
`timescale 1ns/1ps
module jes_interlock (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  // register port
  input  wire jes_pkg::jes_bus_req_s busReq,
  output logic [jes_pkg::DATA_W-1:0] rdata,
  // sources
  input  wire logic [3:0]            debouncedInputWord,
  input  wire logic [5:0]            supervisionStatus,
  // drive sequencing side
  input  wire logic                  vectorMode,
  input  wire logic                  extStartCmd,
  input  wire logic                  fieldbusInch,
  input  wire logic                  jog1Start,
  input  wire logic                  jog2Start,
  output logic                       jogEnabled,
  output logic                       jog1Active,
  output logic                       jog2Active,
  output logic                       extStartGrant,
  output logic                       fbInchGrant
);

  // ************************************************************
  // state
  // ************************************************************
  logic [4:0]                  selector_reg,  selector_next;
  logic                        prevSel_reg,   prevSel_next;
  jes_pkg::jes_state_e         state_reg,     state_next;
  logic [jes_pkg::DATA_W-1:0]  rdata_reg,     rdata_next;
  logic                        selBit;
  logic                        selRise;

  // ************************************************************
  // source selection
  // ************************************************************
  jes_source_mux jes_source_mux_i (
    .selCode            (selector_reg),
    .debouncedInputWord (debouncedInputWord),
    .supervisionStatus  (supervisionStatus),
    .selBit             (selBit)
  );

  assign selRise = selBit & ~prevSel_reg;

  // register writes and read data; reads never stall
  always_comb begin
    selector_next = selector_reg;
    rdata_next    = '0;
    if (busReq.wr && busReq.addr == jes_pkg::ADDR_SEL) begin
      selector_next = busReq.wdata[jes_pkg::SEL_W-1:0];
    end
    if (busReq.rd) begin
      unique case (busReq.addr)
        jes_pkg::ADDR_SEL: begin
          rdata_next[jes_pkg::SEL_W-1:0] = selector_reg;
        end
        jes_pkg::ADDR_STAT: begin
          rdata_next[jes_pkg::STAT_JOG_EN]  = (state_reg == jes_pkg::ST_JOG);
          rdata_next[jes_pkg::STAT_SRC_BIT] = selBit;
          rdata_next[jes_pkg::STAT_VECTOR]  = vectorMode;
          rdata_next[jes_pkg::STAT_EXT_BLK] = extStartCmd & (state_reg == jes_pkg::ST_JOG);
        end
        default: begin
          rdata_next = '0; // unmapped reads give zero
        end
      endcase
    end
  end

  // ************************************************************
  // interlock sequence
  // ************************************************************
  // edge based: a source that is already high when a start clears does not enable
  always_comb begin
    prevSel_next = selBit;
    state_next   = state_reg;
    unique case (state_reg)
      jes_pkg::ST_IDLE: begin
        if (selRise && !extStartCmd && vectorMode) begin
          state_next = jes_pkg::ST_JOG;
        end
      end
      jes_pkg::ST_JOG: begin
        if (!selBit || !vectorMode) begin
          state_next = jes_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = jes_pkg::ST_IDLE; // illegal code recovers to off
      end
    endcase
  end

  // all flip-flops of the block
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      selector_reg <= jes_pkg::SEL_RESET;
      prevSel_reg  <= 1'b0;
      state_reg    <= jes_pkg::ST_IDLE;
      rdata_reg    <= '0;
    end else begin
      selector_reg <= selector_next;
      prevSel_reg  <= prevSel_next;
      state_reg    <= state_next;
      rdata_reg    <= rdata_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // jog enable gates the two start inputs, it never starts a jog by itself
  assign jogEnabled    = (state_reg == jes_pkg::ST_JOG);
  assign jog1Active    = jogEnabled & vectorMode & jog1Start;
  assign jog2Active    = jogEnabled & vectorMode & jog2Start;
  assign extStartGrant = extStartCmd & ~jogEnabled;
  assign fbInchGrant   = fieldbusInch & vectorMode;
  assign rdata         = rdata_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_reset_selector: assert property ($rose(reset_n) |-> selector_reg == jes_pkg::SRC_OFF)
    else $error("selector not zero after reset");
  a_const_off: assert property (selector_reg == jes_pkg::SRC_OFF |-> !selBit)
    else $error("code 0 did not give low");
  a_const_on: assert property (selector_reg == jes_pkg::SRC_ON |-> selBit)
    else $error("code 1 did not give high");
  a_di_route: assert property (selector_reg == 5'h04 |-> selBit == debouncedInputWord[2])
    else $error("code 4 not routed to input bit 2");
  a_sup_route: assert property (selector_reg == 5'h1D |-> selBit == supervisionStatus[5])
    else $error("code 29 not routed to supervision bit 5");
  a_rise_enables: assert property (
    $rose(selBit) && !extStartCmd && vectorMode && !jogEnabled |=> jogEnabled)
    else $error("clean rising enable not taken");
  a_rise_blocked: assert property (
    $rose(selBit) && extStartCmd && !jogEnabled |=> !jogEnabled ##1 1)
    else $error("enable taken during external start");
  a_low_disables: assert property (!selBit |=> !jogEnabled)
    else $error("jogging held with enable low");
  a_vector_only: assert property (!vectorMode |-> !jog1Active && !jog2Active)
    else $error("jog active outside vector mode");
  a_start_block: assert property (jogEnabled && extStartCmd |-> !extStartGrant)
    else $error("external start passed while jogging enabled");
  a_inch_pass: assert property (fieldbusInch && vectorMode |-> fbInchGrant)
    else $error("fieldbus inching blocked");
  a_jog_gate: assert property (jog1Active || jog2Active |-> jogEnabled)
    else $error("jog active without enable");
  a_stat_read: assert property (
    busReq.rd && busReq.addr == jes_pkg::ADDR_STAT |=> rdata[0] == $past(jogEnabled))
    else $error("status read does not show enable");

  // ************************************************************
  // register port checks
  // ************************************************************
  // a write to another address must never disturb the stored code
  a_sel_hold: assert property (
    !(busReq.wr && busReq.addr == jes_pkg::ADDR_SEL) |=> $stable(selector_reg))
    else $error("selector changed without a write");
  // only the low five bits land, the upper bits of the word are dropped
  a_sel_write: assert property (
    busReq.wr && busReq.addr == jes_pkg::ADDR_SEL
      |=> selector_reg == $past(busReq.wdata[jes_pkg::SEL_W-1:0]))
    else $error("selector write did not land");
  // read data stand for one cycle only, so an idle port reads back zero
  a_rd_idle: assert property (!busReq.rd |=> rdata == '0)
    else $error("read data outlived their cycle");

  // ************************************************************
  // source routing checks
  // ************************************************************
  // first entry of each routed range; above are input code 4 and the last supervision code
  a_di_first: assert property (
    selector_reg == jes_pkg::SRC_DI_FIRST |-> selBit == debouncedInputWord[0])
    else $error("code 2 not routed to input bit 0");
  a_sup_first: assert property (
    selector_reg == jes_pkg::SRC_SUP_FIRST |-> selBit == supervisionStatus[0])
    else $error("code 24 not routed to supervision bit 0");
  // unlisted codes are stored but must select off, so a typo fails safe
  a_unlisted_off: assert property (
    (selector_reg > 5'h05 && selector_reg < 5'h18) || selector_reg > 5'h1D |-> !selBit)
    else $error("unlisted code gave a high enable");

  // ************************************************************
  // interlock checks
  // ************************************************************
  // leaving vector mode drops jogging at the next edge
  a_vector_drop: assert property (!vectorMode |=> !jogEnabled)
    else $error("jogging held outside vector mode");
  // without a fresh rise the enable stays off, a held source never re-arms
  a_idle_stays: assert property (!jogEnabled && !$rose(selBit) |=> !jogEnabled)
    else $error("enable taken without a rising source");
  // a high source in vector mode keeps jogging on
  a_jog_hold: assert property (jogEnabled && selBit && vectorMode |=> jogEnabled)
    else $error("jogging dropped with enable high");
  // with jogging off an external start passes straight through
  a_grant_free: assert property (extStartCmd && !jogEnabled |-> extStartGrant)
    else $error("external start blocked while jogging off");

  c_enable_taken: cover property ($rose(jogEnabled));
  c_enable_refused: cover property ($rose(selBit) && extStartCmd);
  c_jog1_run: cover property (jog1Active ##1 !jogEnabled);
  c_sup_source: cover property (selector_reg == 5'h18 && jogEnabled);
  c_ext_blocked: cover property (jogEnabled && extStartCmd);

endmodule : jes_interlock

// file: hw/jes_pkg.sv
// Purpose: shared constants and carriers for the jog enable source and interlock block
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes:   selector codes outside the listed sets read back as written but select off
package jes_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 32;
  localparam int          SEL_W        = 5;
  localparam logic [3:0]  ADDR_SEL     = 4'h0;  // jog enable source selector
  localparam logic [3:0]  ADDR_STAT    = 4'h4;  // interlock status
  localparam logic [4:0]  SEL_RESET    = 5'h00;

  // status word bit positions
  localparam int          STAT_JOG_EN  = 0;
  localparam int          STAT_SRC_BIT = 1;
  localparam int          STAT_VECTOR  = 2;
  localparam int          STAT_EXT_BLK = 3;

  // ************************************************************
  // selector codes
  // ************************************************************
  localparam logic [4:0]  SRC_OFF       = 5'h00;
  localparam logic [4:0]  SRC_ON        = 5'h01;
  localparam logic [4:0]  SRC_DI_FIRST  = 5'h02;
  localparam int          DI_COUNT      = 4;
  localparam logic [4:0]  SRC_SUP_FIRST = 5'h18;
  localparam int          SUP_COUNT     = 6;

  // register port request carrier
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } jes_bus_req_s;

  // interlock state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_JOG  = 2'b10
  } jes_state_e;

endpackage : jes_pkg

// file: hw/jes_source_mux.sv
// Purpose: picks the jog enable bit from the programmed source code
// Assumes: inputs already synchronous and debounced
// Notes:   unknown codes give 0, so a bad setting fails safe with jogging off
`timescale 1ns/1ps
module jes_source_mux (
  // selection
  input  wire logic [4:0] selCode,
  // candidate sources
  input  wire logic [3:0] debouncedInputWord,
  input  wire logic [5:0] supervisionStatus,
  // result
  output logic            selBit
);

  logic [3:0] diHit;
  logic [5:0] supHit;

  // one comparator per input bit
  for (genvar i = 0; i < jes_pkg::DI_COUNT; i++) begin : g_di
    assign diHit[i] = (selCode == 5'(jes_pkg::SRC_DI_FIRST + i)) & debouncedInputWord[i];
  end

  // one comparator per supervision bit
  for (genvar j = 0; j < jes_pkg::SUP_COUNT; j++) begin : g_sup
    assign supHit[j] = (selCode == 5'(jes_pkg::SRC_SUP_FIRST + j)) & supervisionStatus[j];
  end

  // constant on, else any matching hit; constant off falls out as no hit
  assign selBit = (selCode == jes_pkg::SRC_ON) | (|diHit) | (|supHit);

endmodule : jes_source_mux

// file: bench/jes_drive_seq.sv
// Purpose: drive sequencer model on the far side of the jog interlock
// Assumes: levels move just after a rising edge, one clock domain
// Notes:   levels are held whole cycles; no glitch between edges is modelled
`timescale 1ns/1ps
module jes_drive_seq (
  // clock
  input  wire logic       clock,
  // wanted levels: vector, external start, inching, jog 1, jog 2
  input  wire logic [4:0] want,
  // levels toward the block
  output logic            vectorMode,
  output logic            extStartCmd,
  output logic            fieldbusInch,
  output logic            jog1Start,
  output logic            jog2Start
);
  // registered so every level moves just after the edge, like the real sequencer
  // single driver per level; they settle at the first edge, well inside reset
  always @(posedge clock) begin
    {vectorMode, extStartCmd, fieldbusInch, jog1Start, jog2Start} <= want;
  end
endmodule : jes_drive_seq

// file: bench/jes_interlock_test.sv
// Purpose: self-checking bench for the jog enable source and interlock block
// Assumes: one 40 MHz clock, async active-low reset, bus as in the hand-over
// Notes:   every status bit is compared, the blocked-start bit included
`timescale 1ns/1ps
module jes_interlock_test;
  // ************************************************************
  // signals
  // ************************************************************
  logic                 clock = 1'b0;
  logic                 reset_n = 1'b0;
  jes_pkg::jes_bus_req_s busReq = '0;
  logic [31:0]          rdata, expRd;
  logic [3:0]           dIn = 4'h0;
  logic [5:0]           sup = 6'h00;
  logic [4:0]           want = 5'h00, expCode, code;
  logic                 vectorMode, extStartCmd, fieldbusInch, jog1Start, jog2Start;
  logic                 jogEnabled, jog1Active, jog2Active, extStartGrant, fbInchGrant;
  logic                 prevSel, expJog, s;
  int                   seed = 39, n_fail = 0, cmp_count = 0, cycles = 0, r;
  always #12.5 clock = ~clock;
  jes_interlock jes_interlock_i (.clock(clock), .reset_n(reset_n), .busReq(busReq),
    .rdata(rdata), .debouncedInputWord(dIn), .supervisionStatus(sup),
    .vectorMode(vectorMode), .extStartCmd(extStartCmd), .fieldbusInch(fieldbusInch),
    .jog1Start(jog1Start), .jog2Start(jog2Start), .jogEnabled(jogEnabled),
    .jog1Active(jog1Active), .jog2Active(jog2Active), .extStartGrant(extStartGrant),
    .fbInchGrant(fbInchGrant));
  jes_drive_seq jes_drive_seq_i (.clock(clock), .want(want), .vectorMode(vectorMode),
    .extStartCmd(extStartCmd), .fieldbusInch(fieldbusInch), .jog1Start(jog1Start),
    .jog2Start(jog2Start));
  // ************************************************************
  // reference model
  // ************************************************************
  // expected selected bit; unlisted codes fail safe to 0
  function automatic logic sel_of(input logic [4:0] c, input logic [3:0] d,
                                  input logic [5:0] p);
    if (c == jes_pkg::SRC_ON) return 1'b1;
    if (c >= 5'h02 && c <= 5'h05) return d[c - 5'h02];
    if (c >= 5'h18 && c <= 5'h1D) return p[c - 5'h18];
    return 1'b0;
  endfunction : sel_of
  // blocking reads at the edge see pre-edge levels, as the flops do
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {expCode, prevSel, expJog, expRd} = {5'h00, 1'b0, 1'b0, 32'h0};
    end else begin
      s = sel_of(expCode, dIn, sup);
      expRd = 32'h0;
      if (busReq.rd && busReq.addr == jes_pkg::ADDR_SEL) expRd = {27'h0, expCode};
      if (busReq.rd && busReq.addr == jes_pkg::ADDR_STAT) begin
        expRd = {28'h0, extStartCmd & expJog, vectorMode, s, expJog};
      end
      expJog = vectorMode & s & (expJog | (!prevSel & !extStartCmd));
      prevSel = s;
      if (busReq.wr && busReq.addr == jes_pkg::ADDR_SEL) expCode = busReq.wdata[4:0];
    end
  end
  // ************************************************************
  // checks and closing
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  // outputs are settled mid-cycle, well away from the driving edge
  always @(negedge clock) begin
    if (reset_n) begin
      check(rdata, expRd, "read data");
      check({31'h0, jogEnabled}, {31'h0, expJog}, "jog enable");
      check({31'h0, jog1Active}, {31'h0, expJog & vectorMode & jog1Start}, "jog 1");
      check({31'h0, jog2Active}, {31'h0, expJog & vectorMode & jog2Start}, "jog 2");
      check({31'h0, extStartGrant}, {31'h0, extStartCmd & !expJog}, "ext start");
      check({31'h0, fbInchGrant}, {31'h0, fieldbusInch & vectorMode}, "inching");
    end
  end
  // hang guard, far above the planned run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // ************************************************************
  // stimulus
  // ************************************************************
  // one bus request and fresh levels per cycle; sources move slowly so jogging can last
  task automatic step(input logic w, input logic rd, input logic [3:0] a, input logic [4:0] c);
    r = $random(seed);
    busReq <= '{addr: a, wdata: {27'h5A5A5A5, c}, wr: w, rd: rd};
    if (r[1:0] == 2'h0) dIn <= r[7:4];
    if (r[3:2] == 2'h0) sup <= r[13:8];
    want <= {(r[19:16] == 4'h0) ? ~want[4] : want[4], (r[18:16] == 3'h1) ? ~want[3] : want[3],
             r[22:20]};
    @(posedge clock);
  endtask : step
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    step(1'b0, 1'b1, jes_pkg::ADDR_SEL, 5'h00);
    step(1'b1, 1'b0, jes_pkg::ADDR_SEL, jes_pkg::SRC_ON);
    // sweep every code, listed and unlisted, reading status after each
    for (int i = 0; i < 32; i++) begin
      step(1'b1, 1'b0, jes_pkg::ADDR_SEL, i[4:0]);
      step(1'b0, 1'b1, jes_pkg::ADDR_STAT, 5'h00);
      step(1'b0, 1'b1, jes_pkg::ADDR_SEL, 5'h00);
    end
    // mid-run reset: a configured selector must fall back to off
    step(1'b1, 1'b0, jes_pkg::ADDR_SEL, jes_pkg::SRC_ON);
    reset_n <= 1'b0;
    repeat (2) step(1'b0, 1'b0, 4'h0, 5'h00);
    reset_n <= 1'b1;
    step(1'b0, 1'b1, jes_pkg::ADDR_SEL, 5'h00);
    // random traffic with unmapped reads and writes among it
    repeat (4000) begin
      r = $random(seed);
      code = r[12:8];
      case (r[2:0])
        3'h0: step(1'b1, 1'b0, r[7:4], code);
        3'h1: step(1'b0, 1'b1, r[7:4], 5'h00);
        default: step(1'b0, 1'b0, 4'h0, 5'h00);
      endcase
    end
    end_sim();
  end
endmodule : jes_interlock_test
